// *** pidc_pkg.sv ***
// Constants, register map and types for the PID loop controller
package pidc_pkg;

	// ==========================================================
	// Timing
	localparam longint CLK_HZ = 100_000_000;
	localparam longint SAMPLE_PERIOD_S = 1;
	localparam longint SAMPLE_CYCLES = CLK_HZ * SAMPLE_PERIOD_S;

	// ==========================================================
	// Register word addresses
	localparam logic [5:0] ADDR_CTRL = 6'h00;
	localparam logic [5:0] ADDR_SETPOINT = 6'h01;
	localparam logic [5:0] ADDR_PRESET = 6'h02;
	localparam logic [5:0] ADDR_OUT_LIMITS = 6'h03;
	localparam logic [5:0] ADDR_SP_LIMITS = 6'h04;
	localparam logic [5:0] ADDR_SPCHG_LIMIT = 6'h05;
	localparam logic [5:0] ADDR_RATE_LIMIT = 6'h06;
	localparam logic [5:0] ADDR_SWITCH_PTS = 6'h07;
	localparam logic [5:0] ADDR_OS_BAND = 6'h08;
	localparam logic [5:0] ADDR_ACC_CMD = 6'h09;
	localparam logic [5:0] ADDR_SET_BASE = 6'h0A;
	localparam logic [5:0] ADDR_STATUS = 6'h10;
	localparam logic [5:0] ADDR_POS_ACC = 6'h11;
	localparam logic [5:0] ADDR_NEG_ACC = 6'h12;
	localparam logic [5:0] ADDR_PV = 6'h13;
	localparam logic [5:0] ADDR_WSP = 6'h14;

	// ==========================================================
	// Control register fields
	localparam int CTRL_DUAL = 0;
	localparam int CTRL_DIRECT = 1;
	localparam int CTRL_ZERO_SP_STOP = 2;
	localparam int CTRL_HL_EN_LO = 3;
	localparam int CTRL_AUTO_SEL = 6;
	localparam int CTRL_OVERSHOOT = 7;
	localparam int CTRL_RAMP_DET = 8;
	localparam int CTRL_RAMP_LVL1 = 9;
	localparam int CTRL_RAMP_LVL2 = 10;
	localparam int CTRL_SET_LO = 11;
	localparam int CTRL_SRC_LO = 13;
	localparam int CTRL_WIDTH = 17;

	// Accumulator clear command: key in [15:8], bit0 positive, bit1 negative
	localparam logic [7:0] ACC_KEY = 8'hA5;

	// ==========================================================
	// Reset values
	localparam logic [16:0] CTRL_RST = 17'h02000;
	localparam logic [15:0] PB_RST = 16'h0064;
	localparam logic [15:0] RESET_RST = 16'h0000;
	localparam logic [15:0] RATE_RST = 16'h0000;
	localparam logic [7:0] OUT_LO_RST = 8'h00;
	localparam logic [7:0] OUT_HI_RST = 8'h64;
	localparam logic [15:0] SP_LO_RST = 16'hFED4;
	localparam logic [15:0] SP_HI_RST = 16'h270F;
	localparam logic [7:0] SPCHG_RST = 8'h64;
	localparam logic [15:0] SWITCH_RST = 16'h0000;
	localparam logic [15:0] OS_BAND_RST = 16'h0032;

	// ==========================================================
	// Scaling: output in tenths of percent, times and gains fixed point
	localparam longint OUT_FULL = 1000;
	localparam longint P_SCALE = 1_000_000;
	localparam longint I_SCALE = 6000;
	localparam longint D_SCALE = 600_000;
	localparam longint PCT_TO_OUT = 10;

	// ==========================================================
	// Process variable sources
	localparam logic [3:0] SRC_OFF = 4'h0;
	localparam logic [3:0] SRC_IN1 = 4'h1;
	localparam logic [3:0] SRC_IN2 = 4'h2;
	localparam logic [3:0] SRC_IN3 = 4'h3;
	localparam logic [3:0] SRC_GAUGE = 4'h4;

	typedef enum logic [1:0] {
		OS_IDLE = 2'b00,
		OS_APPROACH = 2'b01,
		OS_RAMP = 2'b10
	} pidc_os_e;

endpackage

// *** pidc_loop.sv ***
// PID process loop: register file, setpoint logic, PID math, output shaping
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module pidc_loop #(
	parameter longint TICK_CYCLES = pidc_pkg::SAMPLE_CYCLES,
	parameter int PV_SPAN = 1000,
	parameter int EXP_SHIFT = 3
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Register port
	input wire logic [5:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Sensor pins, signed whole units
	input wire logic [15:0] analog_input_one,
	input wire logic [15:0] analog_input_two,
	input wire logic [15:0] analog_input_three,
	input wire logic [15:0] vacuum_gauge_first_torr,
	input wire logic [15:0] vacuum_gauge_first_micron,
	input wire logic [15:0] vacuum_gauge_second_torr,
	input wire logic [15:0] vacuum_gauge_second_micron,
	input wire logic [15:0] vacuum_gauge_third_torr,
	input wire logic [15:0] vacuum_gauge_third_micron,
	input wire logic [15:0] vacuum_gauge_fourth_torr,
	input wire logic [15:0] vacuum_gauge_fourth_micron,
	input wire logic [2:0] input_high_limit,
	// Recipe programmer, same clock
	input wire logic prog_ramp_step,
	input wire logic [15:0] prog_ramp_sp,
	input wire logic [15:0] prog_final_sp,
	output logic prog_hold,
	// Actuators
	output logic [9:0] out_increase,
	output logic [9:0] out_decrease,
	output logic relay_increase,
	output logic relay_decrease,
	output logic sample_tick
);

	// ==========================================================
	// Input synchronisers
	localparam int NPIN = 11;
	logic [15:0] pin_meta_reg [NPIN];
	logic [15:0] pin_sync_reg [NPIN];
	logic [15:0] pin_raw [NPIN];
	logic [2:0] hl_meta_reg;
	logic [2:0] hl_sync_reg;

	assign pin_raw[0] = analog_input_one;
	assign pin_raw[1] = analog_input_two;
	assign pin_raw[2] = analog_input_three;
	assign pin_raw[3] = vacuum_gauge_first_torr;
	assign pin_raw[4] = vacuum_gauge_first_micron;
	assign pin_raw[5] = vacuum_gauge_second_torr;
	assign pin_raw[6] = vacuum_gauge_second_micron;
	assign pin_raw[7] = vacuum_gauge_third_torr;
	assign pin_raw[8] = vacuum_gauge_third_micron;
	assign pin_raw[9] = vacuum_gauge_fourth_torr;
	assign pin_raw[10] = vacuum_gauge_fourth_micron;

	// Word pins assumed quasi-static; a torn word lasts one enabled clock cycle
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					pin_meta_reg[gi] <= 16'h0000;
					pin_sync_reg[gi] <= 16'h0000;
				end else if (clk_en) begin
					pin_meta_reg[gi] <= pin_raw[gi];
					pin_sync_reg[gi] <= pin_meta_reg[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hl_meta_reg <= 3'h0;
			hl_sync_reg <= 3'h0;
		end else if (clk_en) begin
			hl_meta_reg <= input_high_limit;
			hl_sync_reg <= hl_meta_reg;
		end
	end

	// ==========================================================
	// Sample strobe
	logic [31:0] tick_cnt_reg;
	logic tick;
	assign tick = clk_en && (tick_cnt_reg == 32'(TICK_CYCLES - 1));
	assign sample_tick = tick;

	always_ff @(posedge clk) begin
		if (sys_rst)
			tick_cnt_reg <= 32'h0000_0000;
		else if (clk_en)
			tick_cnt_reg <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
	end

	// ==========================================================
	// Registers
	logic [16:0] ctrl_reg;
	logic signed [15:0] setpoint_reg;
	logic signed [7:0] preset_reg, out_lo_reg, out_hi_reg;
	logic signed [15:0] sp_lo_reg, sp_hi_reg, sw12_reg, sw23_reg, os_band_reg;
	logic [7:0] spchg_reg, rate_lim_reg;
	logic [15:0] pb_reg [3];
	logic [15:0] reset_reg [3];
	logic [15:0] rate_reg [3];
	logic wr_ctrl;
	assign wr_ctrl = clk_en && reg_wr;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_reg <= pidc_pkg::CTRL_RST;
			setpoint_reg <= 16'h0000;
			preset_reg <= 8'h00;
			out_lo_reg <= pidc_pkg::OUT_LO_RST;
			out_hi_reg <= pidc_pkg::OUT_HI_RST;
			sp_lo_reg <= pidc_pkg::SP_LO_RST;
			sp_hi_reg <= pidc_pkg::SP_HI_RST;
			spchg_reg <= pidc_pkg::SPCHG_RST;
			rate_lim_reg <= 8'h00;
			sw12_reg <= pidc_pkg::SWITCH_RST;
			sw23_reg <= pidc_pkg::SWITCH_RST;
			os_band_reg <= pidc_pkg::OS_BAND_RST;
		end else if (wr_ctrl) begin
			case (reg_addr)
				pidc_pkg::ADDR_CTRL: ctrl_reg <= reg_wdata[16:0];
				pidc_pkg::ADDR_SETPOINT: setpoint_reg <= reg_wdata[15:0];
				pidc_pkg::ADDR_PRESET: preset_reg <= reg_wdata[7:0];
				pidc_pkg::ADDR_OUT_LIMITS: begin
					out_lo_reg <= reg_wdata[7:0];
					out_hi_reg <= reg_wdata[15:8];
				end
				pidc_pkg::ADDR_SP_LIMITS: begin
					sp_lo_reg <= reg_wdata[15:0];
					sp_hi_reg <= reg_wdata[31:16];
				end
				pidc_pkg::ADDR_SPCHG_LIMIT: spchg_reg <= reg_wdata[7:0];
				pidc_pkg::ADDR_RATE_LIMIT: rate_lim_reg <= reg_wdata[7:0];
				pidc_pkg::ADDR_SWITCH_PTS: begin
					sw12_reg <= reg_wdata[15:0];
					sw23_reg <= reg_wdata[31:16];
				end
				pidc_pkg::ADDR_OS_BAND: os_band_reg <= reg_wdata[15:0];
				default: ;
			endcase
		end
	end

	// Tuning sets: band+reset word then rate word, three pairs
	generate
		for (gi = 0; gi < 3; gi++) begin : g_set
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					pb_reg[gi] <= pidc_pkg::PB_RST;
					reset_reg[gi] <= pidc_pkg::RESET_RST;
					rate_reg[gi] <= pidc_pkg::RATE_RST;
				end else if (wr_ctrl && reg_addr == pidc_pkg::ADDR_SET_BASE + 6'(2 * gi)) begin
					pb_reg[gi] <= reg_wdata[15:0];
					reset_reg[gi] <= reg_wdata[31:16];
				end else if (wr_ctrl && reg_addr == pidc_pkg::ADDR_SET_BASE + 6'(2 * gi + 1)) begin
					rate_reg[gi] <= reg_wdata[15:0];
				end
			end
		end
	endgenerate

	logic dual, direct, zero_sp_stop, auto_sel, os_en, ramp_det, lvl1, lvl2;
	logic [2:0] hl_en;
	logic [1:0] set_man;
	logic [3:0] src;
	assign dual = ctrl_reg[pidc_pkg::CTRL_DUAL];
	assign direct = ctrl_reg[pidc_pkg::CTRL_DIRECT];
	assign zero_sp_stop = ctrl_reg[pidc_pkg::CTRL_ZERO_SP_STOP];
	assign hl_en = ctrl_reg[pidc_pkg::CTRL_HL_EN_LO +: 3];
	assign auto_sel = ctrl_reg[pidc_pkg::CTRL_AUTO_SEL];
	assign os_en = ctrl_reg[pidc_pkg::CTRL_OVERSHOOT];
	assign ramp_det = ctrl_reg[pidc_pkg::CTRL_RAMP_DET];
	assign lvl1 = ctrl_reg[pidc_pkg::CTRL_RAMP_LVL1];
	assign lvl2 = ctrl_reg[pidc_pkg::CTRL_RAMP_LVL2];
	assign set_man = ctrl_reg[pidc_pkg::CTRL_SET_LO +: 2];
	assign src = ctrl_reg[pidc_pkg::CTRL_SRC_LO +: 4];

	function automatic logic signed [15:0] clamp16(input logic signed [15:0] v,
		input logic signed [15:0] lo, input logic signed [15:0] hi);
		clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// ==========================================================
	// Process variable and setpoint
	logic signed [15:0] pv;
	always_comb begin
		if (src == pidc_pkg::SRC_OFF || src > pidc_pkg::SRC_GAUGE + 4'h7)
			pv = 16'h0000;
		else
			pv = pin_sync_reg[src - 4'h1];
	end

	pidc_pkg::pidc_os_e os_state_reg;
	logic signed [15:0] wsp_reg, target_prev_reg;
	logic ramp_mode, before_band;
	logic signed [15:0] target, wsp;
	assign ramp_mode = ramp_det && prog_ramp_step && os_en;
	assign before_band = ramp_mode && os_state_reg == pidc_pkg::OS_APPROACH;
	assign target = clamp16(ramp_mode ? prog_final_sp : setpoint_reg, sp_lo_reg, sp_hi_reg);

	always_comb begin
		if (before_band)
			wsp = clamp16(prog_ramp_sp, sp_lo_reg, sp_hi_reg);
		else if (os_state_reg == pidc_pkg::OS_IDLE)
			wsp = target;
		else
			wsp = wsp_reg;
	end

	// Overshoot logic
	logic signed [16:0] sp_jump, exp_step;
	logic rising;
	// Jump measured from the last working setpoint; wsp already follows target when idle
	assign sp_jump = 17'(target) - 17'(wsp_reg);
	assign rising = wsp_reg < target;
	assign exp_step = (17'(target) - 17'(wsp_reg)) >>> EXP_SHIFT;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			os_state_reg <= pidc_pkg::OS_IDLE;
			wsp_reg <= 16'h0000;
			target_prev_reg <= 16'h0000;
		end else if (clk_en) begin
			target_prev_reg <= target;
			if (target != target_prev_reg) begin
				if (os_en && (sp_jump > 17'(os_band_reg) || -sp_jump > 17'(os_band_reg))) begin
					os_state_reg <= pidc_pkg::OS_APPROACH;
					wsp_reg <= (sp_jump > 0) ? target - os_band_reg : target + os_band_reg;
				end else begin
					os_state_reg <= pidc_pkg::OS_IDLE;
				end
			end else begin
				case (os_state_reg)
					pidc_pkg::OS_IDLE: wsp_reg <= target;
					pidc_pkg::OS_APPROACH: begin
						if (!os_en)
							os_state_reg <= pidc_pkg::OS_IDLE;
						else if (rising ? pv >= wsp_reg : pv <= wsp_reg)
							os_state_reg <= pidc_pkg::OS_RAMP;
					end
					pidc_pkg::OS_RAMP: begin
						if (!os_en || exp_step == 17'sh0) begin
							wsp_reg <= target;
							os_state_reg <= pidc_pkg::OS_IDLE;
						end else if (tick) begin
							wsp_reg <= wsp_reg + exp_step[15:0];
						end
					end
					default: os_state_reg <= pidc_pkg::OS_IDLE;
				endcase
			end
		end
	end

	// Program waits while its ramp runs ahead of the exponential ramp
	assign prog_hold = ramp_mode && os_state_reg == pidc_pkg::OS_RAMP &&
		(rising ? $signed(prog_ramp_sp) > wsp_reg : $signed(prog_ramp_sp) < wsp_reg);

	// ==========================================================
	// Tuning set selection
	logic [1:0] set_sel;
	logic [15:0] pb_w, reset_w, rate_w;
	always_comb begin
		if (auto_sel)
			set_sel = (pv > sw23_reg) ? 2'd2 : ((pv > sw12_reg) ? 2'd1 : 2'd0);
		else
			set_sel = (set_man > 2'd2) ? 2'd2 : set_man;
		pb_w = pb_reg[set_sel];
		reset_w = reset_reg[set_sel];
		rate_w = rate_reg[set_sel];
		if (ramp_det && lvl1 && before_band) begin
			rate_w = 16'h0000;
			if (lvl2)
				reset_w = 16'h0000;
		end
	end

	// ==========================================================
	// PID computation
	logic signed [16:0] err, dpv;
	logic signed [15:0] pv_prev_reg;
	logic signed [31:0] integ_reg;
	logic signed [63:0] denom, p_term, i_sum, d_term, total;
	logic signed [15:0] lo_t, hi_t, demand, applied_reg;
	logic freeze_reg, onoff, shutdown;

	// Error sign follows action so a positive value always asks for output
	assign err = direct ? 17'(pv) - 17'(wsp) : 17'(wsp) - 17'(pv);
	assign dpv = direct ? 17'(pv) - 17'(pv_prev_reg) : 17'(pv_prev_reg) - 17'(pv);
	assign onoff = pb_w == 16'h0000;
	assign denom = 64'(PV_SPAN) * 64'(pb_w);
	assign lo_t = 16'(out_lo_reg) * 16'(pidc_pkg::PCT_TO_OUT);
	assign hi_t = 16'(out_hi_reg) * 16'(pidc_pkg::PCT_TO_OUT);

	always_comb begin
		p_term = 64'sh0;
		d_term = 64'sh0;
		i_sum = 64'(integ_reg);
		if (!onoff) begin
			p_term = (64'(err) * pidc_pkg::P_SCALE) / denom;
			// Subtracts output as PV movement grows the error
			d_term = -(64'(dpv) * pidc_pkg::D_SCALE * $signed(64'(rate_w))) / denom;
			if (!freeze_reg)
				i_sum = 64'(integ_reg) + p_term * 64'(reset_w);
		end
	end

	always_comb begin
		total = 64'(preset_reg) * pidc_pkg::PCT_TO_OUT + p_term +
			i_sum / pidc_pkg::I_SCALE + d_term;
		if (onoff)
			total = (err > 0) ? 64'(hi_t) : (dual ? 64'(lo_t) : 64'sh0);
		if (total > 64'(hi_t))
			total = 64'(hi_t);
		if (total < 64'(lo_t))
			total = 64'(lo_t);
		if (!dual && total < 0)
			total = 64'sh0;
		demand = 16'(total);
	end

	assign shutdown = (zero_sp_stop && setpoint_reg == 16'sh0) ||
		|(hl_en & hl_sync_reg);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			integ_reg <= 32'sh0;
			pv_prev_reg <= 16'sh0;
		end else if (tick) begin
			pv_prev_reg <= pv;
			// Anti-windup: integral kept within full output
			if (shutdown || onoff)
				integ_reg <= 32'sh0;
			else if (i_sum > pidc_pkg::OUT_FULL * pidc_pkg::I_SCALE)
				integ_reg <= 32'(pidc_pkg::OUT_FULL * pidc_pkg::I_SCALE);
			else if (i_sum < -pidc_pkg::OUT_FULL * pidc_pkg::I_SCALE)
				integ_reg <= -32'(pidc_pkg::OUT_FULL * pidc_pkg::I_SCALE);
			else
				integ_reg <= 32'(i_sum);
		end
	end

	// Setpoint change freezes integral; change beats release in one cycle
	logic signed [15:0] spchg_t;
	assign spchg_t = 16'(spchg_reg) * 16'(pidc_pkg::PCT_TO_OUT);
	always_ff @(posedge clk) begin
		if (sys_rst)
			freeze_reg <= 1'b0;
		else if (clk_en) begin
			if (target != target_prev_reg)
				freeze_reg <= 1'b1;
			else if (applied_reg < spchg_t)
				freeze_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Output slew limit
	logic signed [16:0] slew, delta;
	assign slew = 17'(rate_lim_reg) * 17'(pidc_pkg::PCT_TO_OUT);
	assign delta = 17'(demand) - 17'(applied_reg);

	always_ff @(posedge clk) begin
		if (sys_rst)
			applied_reg <= 16'sh0;
		else if (clk_en && shutdown)
			applied_reg <= 16'sh0;
		else if (tick) begin
			if (slew != 0 && delta > slew)
				applied_reg <= applied_reg + slew[15:0];
			else if (slew != 0 && delta < -slew)
				applied_reg <= applied_reg - slew[15:0];
			else
				applied_reg <= demand;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			out_increase <= 10'h000;
			out_decrease <= 10'h000;
			relay_increase <= 1'b0;
			relay_decrease <= 1'b0;
		end else if (clk_en) begin
			out_increase <= (applied_reg > 0) ? applied_reg[9:0] : 10'h000;
			out_decrease <= (dual && applied_reg < 0) ? 10'((-applied_reg)) : 10'h000;
			relay_increase <= applied_reg > 0;
			relay_decrease <= dual && applied_reg < 0;
		end
	end

	// ==========================================================
	// Output accumulators
	logic [31:0] pos_acc_reg, neg_acc_reg;
	logic clr_pos, clr_neg;
	assign clr_pos = wr_ctrl && reg_addr == pidc_pkg::ADDR_ACC_CMD &&
		reg_wdata[15:8] == pidc_pkg::ACC_KEY && reg_wdata[0];
	assign clr_neg = wr_ctrl && reg_addr == pidc_pkg::ADDR_ACC_CMD &&
		reg_wdata[15:8] == pidc_pkg::ACC_KEY && reg_wdata[1];

	always_ff @(posedge clk) begin
		if (sys_rst)
			pos_acc_reg <= 32'h0000_0000;
		else if (clr_pos)
			pos_acc_reg <= 32'h0000_0000;
		else if (tick && applied_reg > 0)
			pos_acc_reg <= pos_acc_reg + 32'(applied_reg);
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			neg_acc_reg <= 32'h0000_0000;
		else if (clr_neg)
			neg_acc_reg <= 32'h0000_0000;
		else if (tick && applied_reg < 0)
			neg_acc_reg <= neg_acc_reg + 32'((-applied_reg));
	end

	// ==========================================================
	// Read port
	always_ff @(posedge clk) begin
		if (sys_rst)
			reg_rdata <= 32'h0000_0000;
		else if (clk_en && reg_rd) begin
			case (reg_addr)
				pidc_pkg::ADDR_CTRL: reg_rdata <= 32'(ctrl_reg);
				pidc_pkg::ADDR_SETPOINT: reg_rdata <= {16'h0000, setpoint_reg};
				pidc_pkg::ADDR_PRESET: reg_rdata <= {24'h000000, preset_reg};
				pidc_pkg::ADDR_OUT_LIMITS: reg_rdata <= {16'h0000, out_hi_reg, out_lo_reg};
				pidc_pkg::ADDR_SP_LIMITS: reg_rdata <= {sp_hi_reg, sp_lo_reg};
				pidc_pkg::ADDR_SPCHG_LIMIT: reg_rdata <= {24'h000000, spchg_reg};
				pidc_pkg::ADDR_RATE_LIMIT: reg_rdata <= {24'h000000, rate_lim_reg};
				pidc_pkg::ADDR_SWITCH_PTS: reg_rdata <= {sw23_reg, sw12_reg};
				pidc_pkg::ADDR_OS_BAND: reg_rdata <= {16'h0000, os_band_reg};
				6'h0A: reg_rdata <= {reset_reg[0], pb_reg[0]};
				6'h0B: reg_rdata <= {16'h0000, rate_reg[0]};
				6'h0C: reg_rdata <= {reset_reg[1], pb_reg[1]};
				6'h0D: reg_rdata <= {16'h0000, rate_reg[1]};
				6'h0E: reg_rdata <= {reset_reg[2], pb_reg[2]};
				6'h0F: reg_rdata <= {16'h0000, rate_reg[2]};
				pidc_pkg::ADDR_STATUS: reg_rdata <= {9'h000, before_band, prog_hold,
					freeze_reg, shutdown, onoff, set_sel, applied_reg};
				pidc_pkg::ADDR_POS_ACC: reg_rdata <= pos_acc_reg;
				pidc_pkg::ADDR_NEG_ACC: reg_rdata <= neg_acc_reg;
				pidc_pkg::ADDR_PV: reg_rdata <= {16'h0000, pv};
				pidc_pkg::ADDR_WSP: reg_rdata <= {16'h0000, wsp};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end
	end

endmodule

// *** pidc_loop_checker.sv ***
// Port assertions for the PID loop
`timescale 1ns/1ps
module pidc_loop_checker #(
	parameter longint TICK_CYCLES = 20
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Register port
	input wire logic [5:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// Sensors and actuators
	input wire logic [2:0] input_high_limit,
	input wire logic [9:0] out_increase,
	input wire logic [9:0] out_decrease,
	input wire logic relay_increase,
	input wire logic relay_decrease,
	input wire logic sample_tick
);
	// ====
	// Shadow state
	longint cnt_reg;
	logic [16:0] ctrl_reg;
	always_ff @(posedge clk) begin
		if (sys_rst)
			cnt_reg <= 0;
		else if (clk_en)
			cnt_reg <= (cnt_reg == TICK_CYCLES - 1) ? 0 : cnt_reg + 1;
	end
	always_ff @(posedge clk) begin
		if (sys_rst)
			ctrl_reg <= pidc_pkg::CTRL_RST;
		else if (clk_en && reg_wr && reg_addr == pidc_pkg::ADDR_CTRL)
			ctrl_reg <= reg_wdata[16:0];
	end
	// ====
	// Assertions
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence clr_pos_s;
		reg_wr && reg_addr == pidc_pkg::ADDR_ACC_CMD && reg_wdata[15:8] == pidc_pkg::ACC_KEY
			&& reg_wdata[0];
	endsequence
	sequence rd_pos_s;
		reg_rd && reg_addr == pidc_pkg::ADDR_POS_ACC && !sample_tick;
	endsequence
	tick_period_a: assert property (sample_tick == (clk_en && cnt_reg == TICK_CYCLES - 1))
		else $error("sample tick off period");
	out_range_a: assert property (out_increase <= 10'h3E8 && out_decrease <= 10'h3E8)
		else $error("output beyond full scale");
	single_no_dec_a: assert property (!ctrl_reg[0] |=> out_decrease == 10'h000)
		else $error("decrease output in single mode");
	out_hold_a: assert property ($changed(out_increase) && out_increase != 10'h000
		|-> $past(sample_tick, 2)) else $error("output moved off tick");
	relay_inc_a: assert property (relay_increase == (out_increase != 10'h000))
		else $error("increase relay mismatch");
	relay_dec_a: assert property (relay_decrease == (out_decrease != 10'h000))
		else $error("decrease relay mismatch");
	unmapped_zero_a: assert property (reg_rd && reg_addr > pidc_pkg::ADDR_WSP
		|=> reg_rdata == 32'h0) else $error("unmapped read not zero");
	acc_clear_a: assert property (clr_pos_s ##1 !sample_tick ##1 rd_pos_s
		|=> reg_rdata == 32'h0) else $error("accumulator not cleared");
	hl_shutdown_a: assert property ((ctrl_reg[3] && input_high_limit[0])[*8]
		|-> out_increase == 10'h000 && out_decrease == 10'h000) else $error("no shutdown");
endmodule
bind pidc_loop pidc_loop_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (.clk(clk),
	.sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .input_high_limit(input_high_limit),
	.out_increase(out_increase), .out_decrease(out_decrease),
	.relay_increase(relay_increase), .relay_decrease(relay_decrease),
	.sample_tick(sample_tick));

// *** pidc_sensor_model.sv ***
// Sensor side model: process inputs, gauges, high-limit contacts
`timescale 1ns/1ps
module pidc_sensor_model (
	// Bench stimulus
	input wire logic clk,
	input wire logic [15:0] pv,
	input wire logic [2:0] hl,
	// Sensor pins
	output logic [15:0] ain [3],
	output logic [15:0] gauge [8],
	output logic [2:0] input_high_limit
);
	logic [15:0] cyc = 16'h0000;
	assign ain[0] = pv;
	assign ain[1] = pv + 16'h0010;
	assign ain[2] = pv - 16'h0010;
	assign input_high_limit = hl;
	// Gauges wander every cycle so a wrong source pick shows
	always @(negedge clk) cyc <= cyc + 16'h0001;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			gauge[i] = cyc + 16'(i);
		end
	end
endmodule

// *** pidc_loop_test.sv ***
// Self-checking bench for the PID loop
`timescale 1ns/1ps
module pidc_loop_test;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [5:0] reg_addr = 6'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [15:0] pv = 16'h0064;
	logic [2:0] hl = 3'h0;
	logic ramp_step = 1'b0;
	logic [15:0] ramp_sp = 16'h0000, final_sp = 16'h0000;
	logic prog_hold;
	logic [15:0] ain [3];
	logic [15:0] g [8];
	logic [2:0] ihl;
	logic [9:0] out_increase, out_decrease;
	logic relay_increase, relay_decrease, sample_tick;
	int n_errors = 0;
	int cmp_count = 0;
	always #5 clk = ~clk;
	pidc_sensor_model sens (.clk(clk), .pv(pv), .hl(hl), .ain(ain), .gauge(g),
		.input_high_limit(ihl));
	pidc_loop #(.TICK_CYCLES(20)) dut (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .analog_input_one(ain[0]), .analog_input_two(ain[1]),
		.analog_input_three(ain[2]), .vacuum_gauge_first_torr(g[0]),
		.vacuum_gauge_first_micron(g[1]), .vacuum_gauge_second_torr(g[2]),
		.vacuum_gauge_second_micron(g[3]), .vacuum_gauge_third_torr(g[4]),
		.vacuum_gauge_third_micron(g[5]), .vacuum_gauge_fourth_torr(g[6]),
		.vacuum_gauge_fourth_micron(g[7]), .input_high_limit(ihl),
		.prog_ramp_step(ramp_step), .prog_ramp_sp(ramp_sp), .prog_final_sp(final_sp),
		.prog_hold(prog_hold), .out_increase(out_increase), .out_decrease(out_decrease),
		.relay_increase(relay_increase), .relay_decrease(relay_decrease),
		.sample_tick(sample_tick));
	// ====
	// Shared tasks
	task automatic wrap_up();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	// Returns one cycle after the next tick, outputs settled
	task automatic wait_tick();
		int i;
		for (i = 0; i < 60 && sample_tick !== 1'b1; i++) @(negedge clk);
		if (i == 60) begin
			n_errors++;
			wrap_up();
		end
		@(posedge clk);
		@(posedge clk);
		#1;
	endtask
	// ====
	// Scenarios
	task automatic t_reset();
		logic [31:0] d;
		rd(pidc_pkg::ADDR_CTRL, d);
		chk("ctrl", d, 32'(pidc_pkg::CTRL_RST));
		rd(6'h3F, d);
		chk("unmapped", d, 32'h0);
	endtask
	task automatic t_onoff();
		wr(pidc_pkg::ADDR_SET_BASE, 32'h0);
		wr(pidc_pkg::ADDR_SETPOINT, 32'h01F4);
		wait_tick();
		wait_tick();
		chk("onoff", 32'(out_increase), 32'h3E8);
		chk("relay", 32'(relay_increase), 32'h1);
		wr(pidc_pkg::ADDR_OUT_LIMITS, 32'h3C00);
		wait_tick();
		chk("hi limit", 32'(out_increase), 32'h258);
	endtask
	task automatic t_acc();
		logic [31:0] d;
		wait_tick();
		wr(pidc_pkg::ADDR_ACC_CMD, {16'h0, pidc_pkg::ACC_KEY, 8'h01});
		rd(pidc_pkg::ADDR_POS_ACC, d);
		chk("pos clear", d, 32'h0);
		wait_tick();
		rd(pidc_pkg::ADDR_POS_ACC, d);
		chk("pos one", d, 32'h258);
		wait_tick();
		rd(pidc_pkg::ADDR_POS_ACC, d);
		chk("pos two", d, 32'h4B0);
		rd(pidc_pkg::ADDR_NEG_ACC, d);
		chk("neg acc", d, 32'h0);
	endtask
	task automatic t_rate();
		wr(pidc_pkg::ADDR_CTRL, 32'h02004);
		wr(pidc_pkg::ADDR_SETPOINT, 32'h0);
		wr(pidc_pkg::ADDR_RATE_LIMIT, 32'h5);
		wait_tick();
		chk("zero sp", 32'(out_increase), 32'h0);
		wr(pidc_pkg::ADDR_SETPOINT, 32'h01F4);
		wait_tick();
		chk("slew one", 32'(out_increase), 32'h32);
		wait_tick();
		chk("slew two", 32'(out_increase), 32'h64);
	endtask
	task automatic t_hl();
		wr(pidc_pkg::ADDR_CTRL, 32'h02008);
		@(posedge clk);
		hl <= 3'h1;
		wait_tick();
		chk("hl stop", 32'(out_increase), 32'h0);
		@(posedge clk);
		hl <= 3'h0;
	endtask
	task automatic t_dual();
		logic [31:0] d;
		wr(pidc_pkg::ADDR_RATE_LIMIT, 32'h0);
		wr(pidc_pkg::ADDR_OUT_LIMITS, 32'h3CD8);
		wr(pidc_pkg::ADDR_CTRL, 32'h02001);
		wr(pidc_pkg::ADDR_SETPOINT, 32'h0032);
		wait_tick();
		chk("dual dec", 32'(out_decrease), 32'h190);
		chk("dec relay", 32'(relay_decrease), 32'h1);
		wr(pidc_pkg::ADDR_CTRL, 32'h02003);
		wait_tick();
		chk("direct", 32'(out_increase), 32'h258);
		rd(pidc_pkg::ADDR_NEG_ACC, d);
		chk("neg sum", d, 32'h190);
	endtask
	task automatic t_os();
		logic [31:0] d;
		wr(pidc_pkg::ADDR_CTRL, 32'h02180);
		@(posedge clk);
		ramp_step <= 1'b1;
		ramp_sp <= 16'h00C8;
		final_sp <= 16'h03E8;
		rd(pidc_pkg::ADDR_WSP, d);
		chk("ramp wsp", d, 32'h00C8);
		@(posedge clk);
		pv <= 16'h03E8;
		ramp_sp <= 16'h03DE;
		repeat (4) @(posedge clk);
		#1;
		chk("prog hold", 32'(prog_hold), 32'h1);
		wait_tick();
		rd(pidc_pkg::ADDR_WSP, d);
		chk("exp ramp", d, 32'h03BC);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset();
		t_onoff();
		t_acc();
		t_rate();
		t_hl();
		t_dual();
		t_os();
		wrap_up();
	end
endmodule
